// ---- hdl/btr_consts.svh ----
// register offsets, field positions and reset values of the baseband control registers
`ifndef BTR_CONSTS_SVH
`define BTR_CONSTS_SVH
`define BTR_ADDR_W 7
`define BTR_OFS_INTERRUPT_ROUTING 7'h02
`define BTR_OFS_TRANSMIT_SETUP 7'h03
`define BTR_OFS_TX_FIFO_BASE 7'h04
`define BTR_OFS_RECEIVE_SETUP_MAIN 7'h08
`define BTR_OFS_RECEIVE_SAMPLING_DELAY 7'h09
`define BTR_RST_REG 8'h00
`define BTR_RST_FIFO_WORD 10'h000
`define BTR_IR_CODEC_CLK 7
`define BTR_IR_SECOND_HI 6
`define BTR_IR_SECOND_LO 4
`define BTR_IR_TX_CLK 3
`define BTR_IR_FIRST_HI 2
`define BTR_IR_FIRST_LO 0
`define BTR_TS_SYM_ALIGN 7
`define BTR_TS_DW_SAMPLE_RATE 6
`define BTR_TS_DIRECT_WRITE 5
`define BTR_TS_MOD_BYPASS 4
`define BTR_TS_TX_ENABLE 3
`define BTR_TS_RAMP_LINEAR 2
`define BTR_TS_RAMP_ENABLE 1
`define BTR_TS_TX_COEF_RESET 0
`define BTR_RS_FRAME32 7
`define BTR_RS_ODD_SAMPLES 6
`define BTR_RS_CHAN_TAG 5
`define BTR_RS_LSB_FIRST 4
`define BTR_RS_RX_ENABLE 3
`define BTR_RS_READBACK2 2
`define BTR_RS_READBACK1 1
`define BTR_RS_RX_COEF_RESET 0
`define BTR_FW_RAMP_UP 9
`define BTR_FW_MULTI_SYMBOL 8
`define BTR_FW_POINT_HI 2
`define BTR_FW_POINT_LO 0
`define BTR_RD_Q_HI 7
`define BTR_RD_Q_LO 4
`define BTR_RD_I_HI 3
`define BTR_RD_I_LO 0
`endif

// ---- hdl/btr_control_regs.sv ----
// control register bank of the radio baseband: interrupt routing, transmit and receive set-up
`include "btr_consts.svh"
`default_nettype none

module btr_control_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire btr_pkg::btr_bus_req_s bus_req,
  output logic [7:0] rdata,
  input wire logic [2:0] status_irq,
  input wire logic codec_sample_clk,
  input wire logic tx_sample_clk,
  input wire logic ramp_down_done,
  output logic interrupt_pin_first_n,
  output logic interrupt_pin_second_n,
  output btr_pkg::btr_tx_ctrl_s tx_ctrl,
  output btr_pkg::btr_fifo_word_s fifo_word,
  output logic symbol_realign,
  output logic tx_path_active,
  output logic [2:0] fifo_symbol_count,
  output logic [2:0] constellation_point,
  output logic ramp_target_full,
  output btr_pkg::btr_rx_ctrl_s rx_ctrl
);
  import btr_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [7:0] interrupt_routing;
  logic [7:0] transmit_setup;
  logic [7:0] receive_setup_main;
  logic [7:0] receive_sampling_delay;
  logic [9:0] transmit_fifo_word;
  logic word_valid;

  wire sel_ir = bus_req.addr == `BTR_OFS_INTERRUPT_ROUTING;
  wire sel_ts = bus_req.addr == `BTR_OFS_TRANSMIT_SETUP;
  wire [4:0] fifo_page = 5'(`BTR_OFS_TX_FIFO_BASE >> 2);
  wire sel_fifo = bus_req.addr[6:2] == fifo_page;
  wire sel_rs = bus_req.addr == `BTR_OFS_RECEIVE_SETUP_MAIN;
  wire sel_rd = bus_req.addr == `BTR_OFS_RECEIVE_SAMPLING_DELAY;
  wire wr_fifo = bus_req.wr && sel_fifo;
  // address low bits carry the upper data bits of the fifo word
  wire [9:0] next_fifo_word = {bus_req.addr[1:0], bus_req.wdata};

  // fifo window is write only and unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    if (!bus_req.rd) begin
      next_rdata = 8'h00;
    end else if (sel_ir) begin
      next_rdata = interrupt_routing;
    end else if (sel_ts) begin
      next_rdata = transmit_setup;
    end else if (sel_rs) begin
      next_rdata = receive_setup_main;
    end else if (sel_rd) begin
      next_rdata = receive_sampling_delay;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // one write enable per register keeps each flop block to a single decision
  wire wr_ir = bus_req.wr && sel_ir;
  wire wr_ts = bus_req.wr && sel_ts;
  wire wr_rs = bus_req.wr && sel_rs;
  wire wr_rd = bus_req.wr && sel_rd;

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `BTR_RST_REG;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_routing <= `BTR_RST_REG;
    end else if (wr_ir) begin
      interrupt_routing <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_setup <= `BTR_RST_REG;
    end else if (wr_ts) begin
      transmit_setup <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_setup_main <= `BTR_RST_REG;
    end else if (wr_rs) begin
      receive_setup_main <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_sampling_delay <= `BTR_RST_REG;
    end else if (wr_rd) begin
      receive_sampling_delay <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_fifo_word <= `BTR_RST_FIFO_WORD;
      word_valid <= 1'b0;
    end else begin
      word_valid <= wr_fifo;
      if (wr_fifo) begin
        transmit_fifo_word <= next_fifo_word;
      end
    end
  end

  // ----------------------------------------
  // interrupt pin routing
  // ----------------------------------------
  // pins are active low; status sources are taken as active-high levels
  wire [2:0] first_gate = interrupt_routing[`BTR_IR_FIRST_HI:`BTR_IR_FIRST_LO];
  wire [2:0] second_gate = interrupt_routing[`BTR_IR_SECOND_HI:`BTR_IR_SECOND_LO];
  wire first_status = |(first_gate & status_irq);
  wire second_status = |(second_gate & status_irq);
  wire first_clk = interrupt_routing[`BTR_IR_TX_CLK] & tx_sample_clk;
  // codec clock only toggles while the codec runs, so nothing extra to gate here
  wire second_clk = interrupt_routing[`BTR_IR_CODEC_CLK] & codec_sample_clk;

  wire next_first_n = ~(first_status | first_clk);
  wire next_second_n = ~(second_status | second_clk);

  // registered pins: a glitch on a status input reaches the host only if it spans a clk edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pin_first_n <= 1'b1;
    end else begin
      interrupt_pin_first_n <= next_first_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pin_second_n <= 1'b1;
    end else begin
      interrupt_pin_second_n <= next_second_n;
    end
  end

  // ----------------------------------------
  // transmit control
  // ----------------------------------------
  assign tx_ctrl.sym_align = transmit_setup[`BTR_TS_SYM_ALIGN];
  assign tx_ctrl.dw_sample_rate = transmit_setup[`BTR_TS_DW_SAMPLE_RATE];
  assign tx_ctrl.direct_write = transmit_setup[`BTR_TS_DIRECT_WRITE];
  assign tx_ctrl.mod_bypass = transmit_setup[`BTR_TS_MOD_BYPASS];
  assign tx_ctrl.tx_enable = transmit_setup[`BTR_TS_TX_ENABLE];
  assign tx_ctrl.ramp_linear = transmit_setup[`BTR_TS_RAMP_LINEAR];
  assign tx_ctrl.ramp_enable = transmit_setup[`BTR_TS_RAMP_ENABLE];
  assign tx_ctrl.coef_reset = transmit_setup[`BTR_TS_TX_COEF_RESET];

  assign fifo_word.word = transmit_fifo_word;
  assign fifo_word.valid = word_valid;

  // realign pulse on the rising edge of transmit enable
  logic tx_enable_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_enable_q <= 1'b0;
    end else begin
      tx_enable_q <= tx_ctrl.tx_enable;
    end
  end
  assign symbol_realign = tx_ctrl.sym_align & tx_ctrl.tx_enable & ~tx_enable_q;

  // direct write takes the filter input, so the fifo word steers only the active flag then
  wire use_modulator = ~tx_ctrl.direct_write;
  wire ramp_bit = transmit_fifo_word[`BTR_FW_RAMP_UP];
  wire [2:0] next_count = transmit_fifo_word[`BTR_FW_MULTI_SYMBOL] ? 3'h4 : 3'h1;

  wire take_word = word_valid && use_modulator;
  wire [2:0] fifo_point = transmit_fifo_word[`BTR_FW_POINT_HI:`BTR_FW_POINT_LO];
  // bypass sends one absolute point per word
  wire [2:0] next_symbols = tx_ctrl.mod_bypass ? 3'h1 : next_count;
  wire [2:0] next_point = tx_ctrl.mod_bypass ? fifo_point : 3'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_target_full <= 1'b0;
    end else if (take_word) begin
      ramp_target_full <= ramp_bit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_symbol_count <= 3'h0;
    end else if (take_word) begin
      fifo_symbol_count <= next_symbols;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      constellation_point <= 3'h0;
    end else if (take_word) begin
      constellation_point <= next_point;
    end
  end

  // active flag: set by enable with a ramp-up word, cleared at end of ramp-down
  logic next_active;
  always_comb begin
    next_active = tx_path_active;
    if (!tx_ctrl.tx_enable) begin
      next_active = 1'b0;
    end else if (word_valid && ramp_bit) begin
      next_active = 1'b1;
    end else if (ramp_down_done && !ramp_target_full) begin
      next_active = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_path_active <= 1'b0;
    end else begin
      tx_path_active <= next_active;
    end
  end

  // ----------------------------------------
  // receive control
  // ----------------------------------------
  assign rx_ctrl.frame32 = receive_setup_main[`BTR_RS_FRAME32];
  assign rx_ctrl.odd_samples = receive_setup_main[`BTR_RS_ODD_SAMPLES];
  assign rx_ctrl.chan_tag = receive_setup_main[`BTR_RS_CHAN_TAG];
  assign rx_ctrl.lsb_first = receive_setup_main[`BTR_RS_LSB_FIRST];
  assign rx_ctrl.rx_enable = receive_setup_main[`BTR_RS_RX_ENABLE];
  assign rx_ctrl.readback2 = receive_setup_main[`BTR_RS_READBACK2];
  assign rx_ctrl.readback1 = receive_setup_main[`BTR_RS_READBACK1];
  assign rx_ctrl.coef_reset = receive_setup_main[`BTR_RS_RX_COEF_RESET];
  assign rx_ctrl.q_delay = receive_sampling_delay[`BTR_RD_Q_HI:`BTR_RD_Q_LO];
  assign rx_ctrl.i_delay = receive_sampling_delay[`BTR_RD_I_HI:`BTR_RD_I_LO];
endmodule // btr_control_regs
`default_nettype wire

// ---- hdl/btr_pkg.sv ----
// types shared by the baseband control register bank
`default_nettype none
package btr_pkg;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } btr_bus_req_s;

  typedef struct packed {
    logic [9:0] word;
    logic valid;
  } btr_fifo_word_s;

  typedef struct packed {
    logic frame32;
    logic odd_samples;
    logic chan_tag;
    logic lsb_first;
    logic rx_enable;
    logic readback2;
    logic readback1;
    logic coef_reset;
    logic signed [3:0] q_delay;
    logic signed [3:0] i_delay;
  } btr_rx_ctrl_s;

  typedef struct packed {
    logic sym_align;
    logic dw_sample_rate;
    logic direct_write;
    logic mod_bypass;
    logic tx_enable;
    logic ramp_linear;
    logic ramp_enable;
    logic coef_reset;
  } btr_tx_ctrl_s;
endpackage : btr_pkg
`default_nettype wire

// ---- testbench/btr_control_regs_bench.sv ----
// self-checking bench of the baseband control register bank
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value at %0t got %h expected %h", $time, (a), (e)); end end
module btr_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import btr_pkg::*;
  logic clk, resetn, codec_sample_clk, tx_sample_clk, ramp_down_done;
  logic interrupt_pin_first_n, interrupt_pin_second_n, symbol_realign, tx_path_active, ramp_target_full;
  logic [2:0] status_irq, fifo_symbol_count, constellation_point;
  logic [7:0] rdata, d;
  btr_bus_req_s bus_req;
  btr_tx_ctrl_s tx_ctrl;
  btr_fifo_word_s fifo_word;
  btr_rx_ctrl_s rx_ctrl;
  int err_count = 0;
  int cmp_count = 0;
  logic [6:0] adr [4] = '{7'h02, 7'h03, 7'h08, 7'h09};
  logic [7:0] val [4] = '{8'h55, 8'h96, 8'ha4, 8'h87};
  logic [7:0] irv [5] = '{8'h01, 8'h20, 8'h04, 8'h08, 8'h80};
  logic [2:0] stv [5] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h0};
  logic [1:0] pins [5] = '{2'b01, 2'b10, 2'b11, 2'b01, 2'b10};
  btr_control_regs btr_control_regs_i (
    .clk(clk),
    .resetn(resetn),
    .bus_req(bus_req),
    .rdata(rdata),
    .status_irq(status_irq),
    .codec_sample_clk(codec_sample_clk),
    .tx_sample_clk(tx_sample_clk),
    .ramp_down_done(ramp_down_done),
    .interrupt_pin_first_n(interrupt_pin_first_n),
    .interrupt_pin_second_n(interrupt_pin_second_n),
    .tx_ctrl(tx_ctrl),
    .fifo_word(fifo_word),
    .symbol_realign(symbol_realign),
    .tx_path_active(tx_path_active),
    .fifo_symbol_count(fifo_symbol_count),
    .constellation_point(constellation_point),
    .ramp_target_full(ramp_target_full),
    .rx_ctrl(rx_ctrl)
  );
  btr_host_model btr_host_model_i (
    .clk(clk),
    .rdata(rdata),
    .bus_req(bus_req)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    btr_host_model_i.rd(a, d);
    `CHK(d, e)
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    status_irq = 3'h0;
    codec_sample_clk = 1'b0;
    tx_sample_clk = 1'b0;
    ramp_down_done = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (adr[i]) rdchk(adr[i], 8'h00);
    `CHK({interrupt_pin_first_n, interrupt_pin_second_n}, 2'b11)
    `CHK(tx_path_active, 1'b0)
    $display("test reset done");
    // coefficient reset bits stay low, bit 6 low without direct write
    foreach (adr[i]) begin
      btr_host_model_i.wr(adr[i], val[i]);
      rdchk(adr[i], val[i]);
    end
    `CHK(tx_ctrl, 8'h96)
    `CHK({rx_ctrl.q_delay, rx_ctrl.i_delay}, 8'h87)
    btr_host_model_i.wr(7'h0a, 8'hff);
    rdchk(7'h0a, 8'h00);
    rdchk(7'h05, 8'h00);
    $display("test registers done");
    foreach (irv[i]) begin
      btr_host_model_i.wr(7'h02, irv[i]);
      status_irq <= stv[i];
      tx_sample_clk <= (i == 3);
      codec_sample_clk <= (i >= 3);
      repeat (3) @(posedge clk);
      `CHK({interrupt_pin_first_n, interrupt_pin_second_n}, pins[i])
    end
    $display("test routing done");
    btr_host_model_i.wr(7'h03, 8'h00);
    for (int i = 0; i < 4; i++) begin
      btr_host_model_i.wr(7'h04 + 7'(i), 8'h1b);
      @(posedge clk);
      `CHK(fifo_word.word, {2'(i), 8'h1b})
      @(posedge clk);
      `CHK(fifo_symbol_count, (i % 2) ? 3'h4 : 3'h1)
      `CHK(ramp_target_full, i >= 2)
    end
    btr_host_model_i.wr(7'h03, 8'h10);
    btr_host_model_i.wr(7'h04, 8'h05);
    repeat (2) @(posedge clk);
    `CHK(constellation_point, 3'h5)
    `CHK(fifo_symbol_count, 3'h1)
    $display("test fifo done");
    btr_host_model_i.wr(7'h03, 8'h00);
    btr_host_model_i.wr(7'h06, 8'h00);
    btr_host_model_i.wr(7'h03, 8'h8a);
    @(negedge clk);
    `CHK(symbol_realign, 1'b1)
    btr_host_model_i.wr(7'h06, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(tx_path_active, 1'b1)
    btr_host_model_i.wr(7'h04, 8'h00);
    @(posedge clk);
    ramp_down_done <= 1'b1;
    @(posedge clk);
    ramp_down_done <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(tx_path_active, 1'b0)
    btr_host_model_i.wr(7'h03, 8'h00);
    @(negedge clk);
    `CHK(tx_ctrl, 8'h00)
    $display("test path done");
    results();
  end
  // the tests need about 125 cycles
  initial begin
    #200us;
    err_count++;
    results();
  end
endmodule // btr_control_regs_bench
`default_nettype wire

// ---- testbench/btr_control_regs_checker.sv ----
// port assertions of the baseband control register bank
`default_nettype none
module btr_control_regs_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire btr_pkg::btr_bus_req_s bus_req,
  input wire logic [7:0] rdata,
  input wire logic [2:0] status_irq,
  input wire logic codec_sample_clk,
  input wire logic tx_sample_clk,
  input wire logic interrupt_pin_first_n,
  input wire logic interrupt_pin_second_n,
  input wire btr_pkg::btr_tx_ctrl_s tx_ctrl,
  input wire btr_pkg::btr_fifo_word_s fifo_word,
  input wire logic symbol_realign,
  input wire logic tx_path_active,
  input wire logic [2:0] fifo_symbol_count,
  input wire logic [2:0] constellation_point,
  input wire btr_pkg::btr_rx_ctrl_s rx_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  import btr_pkg::*;
  // ----------------------------------------
  // shadow of the routing register
  // ----------------------------------------
  logic [7:0] ir;
  wire fifo_wr = bus_req.wr && bus_req.addr[6:2] == 5'h01;
  wire c1 = |(ir[2:0] & status_irq) || (ir[3] && tx_sample_clk);
  wire c2 = |(ir[6:4] & status_irq) || (ir[7] && codec_sample_clk);
  wire [6:0] a = bus_req.addr;
  wire [7:0] rexp = a == 7'h02 ? ir : a == 7'h03 ? tx_ctrl :
    a == 7'h08 ? rx_ctrl[15:8] : a == 7'h09 ? rx_ctrl[7:0] : 8'h00;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ir <= 8'h00;
    else if (bus_req.wr && a == 7'h02) ir <= bus_req.wdata;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_first_pin_route: assert property (
    interrupt_pin_first_n == !$past(c1))
    else $error("first interrupt pin wrong");
  a_second_pin_route: assert property (
    interrupt_pin_second_n == !$past(c2))
    else $error("second interrupt pin wrong");
  a_fifo_word_form: assert property (
    fifo_wr |=> fifo_word.valid && fifo_word.word == {$past(a[1:0]), $past(bus_req.wdata)})
    else $error("fifo word wrong");
  a_fifo_valid_pulse: assert property (
    !fifo_wr |=> !fifo_word.valid)
    else $error("fifo valid without write");
  a_setup_write: assert property (
    bus_req.wr && a == 7'h03 |=> tx_ctrl == $past(bus_req.wdata))
    else $error("transmit setup wrong");
  a_rx_write: assert property (
    bus_req.wr && a[6:1] == 6'h04 |=> ($past(a[0]) ? rx_ctrl[7:0] : rx_ctrl[15:8]) == $past(bus_req.wdata))
    else $error("receive setup wrong");
  a_read_data: assert property (
    bus_req.rd |=> rdata == $past(rexp))
    else $error("read data wrong");
  a_rdata_idle: assert property (
    !bus_req.rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_symbol_count: assert property (
    fifo_word.valid && !tx_ctrl.direct_write && !tx_ctrl.mod_bypass
    |=> fifo_symbol_count == ($past(fifo_word.word[8]) ? 3'h4 : 3'h1))
    else $error("symbol count wrong");
  a_bypass_point: assert property (
    fifo_word.valid && !tx_ctrl.direct_write && tx_ctrl.mod_bypass
    |=> constellation_point == $past(fifo_word.word[2:0]))
    else $error("constellation point wrong");
  a_realign_pulse: assert property (
    $rose(tx_ctrl.tx_enable) && tx_ctrl.sym_align |-> ##[0:1] symbol_realign)
    else $error("no symbol realign");
  a_path_off: assert property (
    !tx_ctrl.tx_enable ##1 !tx_ctrl.tx_enable |-> !tx_path_active)
    else $error("path active while disabled");
endmodule // btr_control_regs_checker
bind btr_control_regs btr_control_regs_checker btr_control_regs_checker_i (.*);
`default_nettype wire

// ---- testbench/btr_host_model.sv ----
// host processor model driving the register port
`default_nettype none
module btr_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var btr_pkg::btr_bus_req_s bus_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import btr_pkg::*;
  initial bus_req = '0;
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '{~a, 8'hff, 1'b0, 1'b0};
    @(posedge clk);
    d = rdata;
  endtask
endmodule // btr_host_model
`default_nettype wire
